// File: logic/dfd_decoder.sv
// instruction format decoder: splits 24-bit words into opcode, operands, cycle count
// assumes the fetch path gives one word per I_INSN_VALID plus the prefetched next word
//
// Contract
// RULE1: every single word is 24 bits, 8-bit opcode plus operands.
// RULE2: only three opcodes are two-word forms; all others take one word.
// RULE3: a two-word form spans 48 bits; second word upper eight bits zero.
// RULE4: a lone second word decodes as a no-operation.
// RULE5: one cycle normally; two when condition true or program counter changes.
// RULE6: branch, indirect call/jump, table access, returns take two or three cycles.
// RULE7: a taken skip costs two cycles, three over a two-word instruction.
// RULE8: double-word moves and two-word instructions take two cycles.
// RULE9: file register forms give address and destination, file or register zero.
// RULE10: file register address is a direct address from zero to 0x1FFF.
// RULE11: ten-bit unsigned literal limited to 255 in byte mode, 1023 in word.
// RULE12: 23-bit program address literal has its lowest bit zero.
// RULE13: a 4-bit field selects bit 0 to 15 of the target word.
// RULE14: write-back goes to register 13 or its location with post-increment by 2.
// RULE15: every DSP instruction selects accumulator A or B, always.
// RULE16: five general flags: carry, digit carry, negative, overflow, sticky zero.
// RULE17: four DSP flags: overflow and saturation of each accumulator.
// RULE18: ten-bit signed literal is two's complement, -512 to 511.
// RULE19: three-operand forms: plain first source, moded second source and destination.
// RULE20: bit number comes from a literal or from the base register contents.
// RULE21: literal arithmetic uses its destination only when not the first source.
// RULE22: width is word unless byte or double-word is encoded.
// RULE23: non-multiplying DSP shift amount comes from a register or a literal.
// RULE24: all decode outputs for a word appear together at one stage.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module dfd_decoder
	import dfd_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST_B,
	input  wire logic        I_INSN_VALID,
	input  wire logic [23:0] I_INSN,
	input  wire logic [23:0] I_NEXT_INSN,
	input  wire logic        I_COND_TRUE,
	input  wire logic [8:0]  I_SR_MASK,
	input  wire logic [8:0]  I_SR_VAL,
	input  wire logic [3:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic             O_DEC_VALID,
	output logic [7:0]       O_OPCODE,
	output logic [2:0]       O_CLASS,
	output logic             O_TWO_WORD,
	output logic [1:0]       O_CYCLES,
	output logic [1:0]       O_WIDTH,
	output logic [3:0]       O_BASE_REG,
	output logic [3:0]       O_SRC_REG,
	output logic [2:0]       O_SRC_MODE,
	output logic [3:0]       O_DST_REG,
	output logic [2:0]       O_DST_MODE,
	output logic             O_DST_USED,
	output logic [12:0]      O_FILE_ADDR,
	output logic             O_DST_IS_WREG0,
	output logic [9:0]       O_ULIT10,
	output logic [15:0]      O_SLIT16,
	output logic [22:0]      O_PROG_ADDR,
	output logic [3:0]       O_BIT_POS,
	output logic             O_BIT_INDIRECT,
	output logic             O_ACC_B,
	output logic             O_AWB_EN,
	output logic             O_AWB_POSTINC,
	output logic             O_SHIFT_LIT,
	output logic [5:0]       O_SHIFT_AMT,
	output logic [3:0]       O_XPF,
	output logic [3:0]       O_YPF,
	output logic             O_FMT_ERR,
	output logic [8:0]       O_SR,
	output logic [31:0]      O_RDATA
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_two_word(input logic [7:0] op);
		is_two_word = (op == OP_CALL) || (op == OP_GOTO) || (op == OP_DO); // RULE2
	endfunction

	dfd_state_t  state_q;
	dfd_state_t  state_d;
	logic [23:0] word1_q;
	logic        en_q;
	logic [8:0]  sr_q;
	logic [7:0]  op;
	logic [3:0]  nib;
	logic [23:0] w;
	logic        take;
	logic        dv_d;
	dfd_class_t  cls_d;
	dfd_width_t  wid_d;
	logic        two_d;
	logic [1:0]  cyc_d;
	logic        dused_d;
	logic        dwreg_d;
	logic [9:0]  ulit_d;
	logic [15:0] slit_d;
	logic [22:0] pa_d;
	logic        bind_d;
	logic        awben_d;
	logic        awbinc_d;
	logic        shlit_d;
	logic [5:0]  sham_d;
	logic        err_d;

	// ****************************************
	// word sequencing
	// ****************************************
	assign w    = (state_q == ST_WORD2) ? word1_q : I_INSN;
	assign op   = w[INSN_W-1:OP_LSB]; // RULE1
	assign nib  = op[7:4];
	assign take = I_INSN_VALID && en_q;

	always_comb begin
		state_d = state_q;
		if (take) begin
			unique case (state_q)
				ST_FIRST: begin
					if (is_two_word(op))
						state_d = ST_WORD2;
				end
				ST_WORD2: begin
					state_d = ST_FIRST;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state_q <= ST_FIRST;
			word1_q <= 24'h00_0000;
		end else begin
			state_q <= state_d;
			if (take && state_q == ST_FIRST)
				word1_q <= I_INSN;
		end
	end

	// ****************************************
	// decode
	// ****************************************
	always_comb begin
		dv_d     = take && !(state_q == ST_FIRST && is_two_word(op));
		cls_d    = C_NOP;
		wid_d    = W_WORD; // RULE22
		two_d    = 1'b0;
		cyc_d    = CYC_1; // RULE5
		dused_d  = 1'b1;
		dwreg_d  = 1'b0;
		ulit_d   = w[F_LIT_LSB +: 10];
		slit_d   = {{6{w[F_LIT_LSB+9]}}, w[F_LIT_LSB +: 10]}; // RULE18
		pa_d     = 23'h00_0000;
		bind_d   = 1'b0;
		awben_d  = 1'b0;
		awbinc_d = 1'b0;
		shlit_d  = w[F_SHLIT];
		sham_d   = w[5:0];
		err_d    = 1'b0;
		if (w[F_BYTE] && nib != NB_DSP && nib != NB_CTRL && nib != NB_BRC)
			wid_d = W_BYTE; // RULE22
		unique case (nib)
			NB_CTRL: begin
				cls_d = (op == OP_NOP) ? C_NOP : C_CTRL; // RULE4
				wid_d = W_WORD;
				if (is_two_word(op)) begin
					two_d = 1'b1;
					cyc_d = CYC_2; // RULE8
					pa_d  = {I_INSN[6:0], w[15:1], 1'b0}; // RULE12
					err_d = (I_INSN[INSN_W-1:F_W2_LSB] != W2_HIGH) || w[0]; // RULE3
				end else if (op == OP_RET || op == OP_RETI) begin
					cyc_d = CYC_3; // RULE6
				end else if (op == OP_IND || op == OP_TBLR || op == OP_TBLW) begin
					cyc_d = CYC_2; // RULE6
				end
			end
			NB_BRC: begin
				cls_d = C_CTRL;
				wid_d = W_WORD;
				slit_d = w[15:0];
				if (op == OP_BRA || I_COND_TRUE)
					cyc_d = CYC_2; // RULE5 RULE6
			end
			NB_SLIT: begin
				cls_d = C_LIT;
				if (w[F_BYTE])
					ulit_d = w[F_LIT_LSB +: 10] & LIT8_MASK; // RULE11
			end
			NB_BIT: begin
				cls_d  = C_BIT;
				wid_d  = W_WORD;
				bind_d = op[0]; // RULE20
				if ((op == OP_SKIP0 || op == OP_SKIP1) && I_COND_TRUE)
					cyc_d = is_two_word(I_NEXT_INSN[INSN_W-1:OP_LSB]) ? CYC_3 : CYC_2; // RULE7
			end
			NB_LITF: begin
				if (op[3]) begin
					cls_d   = C_FILE;
					dwreg_d = !w[F_FDIR]; // RULE9
				end else begin
					cls_d   = C_LIT;
					dused_d = 1'b0; // RULE21
					if (w[F_BYTE]) begin
						ulit_d = w[F_LIT_LSB +: 10] & LIT8_MASK; // RULE11
						err_d  = (w[F_LIT_LSB +: 10] & ~LIT8_MASK) != 10'h000;
					end
				end
			end
			NB_DSP: begin
				wid_d = W_WORD;
				if (op[3]) begin
					cls_d = C_DSP;
					if (!w[F_SHLIT])
						sham_d = {2'b00, w[3:0]}; // RULE23
				end else begin
					cls_d    = C_MAC;
					awben_d  = (w[F_AWB_LSB +: 2] == AWB_DIRECT) || (w[F_AWB_LSB +: 2] == AWB_POSTINC); // RULE14
					awbinc_d = (w[F_AWB_LSB +: 2] == AWB_POSTINC);
				end
			end
			default: begin
				cls_d = C_DEFAULT_WORKING_REGISTER; // RULE19
				if (op == OP_MOVD) begin
					wid_d = W_DOUBLE;
					cyc_d = CYC_2; // RULE8
				end
				if (w[F_SMODE +: 3] == MODE_LIT) begin
					ulit_d  = {5'b00000, w[4:0]};
					dused_d = w[F_DST_LSB +: 4] != w[F_BASE_LSB +: 4]; // RULE21
				end
			end
		endcase
	end

	// ****************************************
	// decode output stage
	// ****************************************
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_DEC_VALID    <= 1'b0;
			O_OPCODE       <= OP_NOP;
			O_CLASS        <= C_NOP;
			O_TWO_WORD     <= 1'b0;
			O_CYCLES       <= CYC_1;
			O_WIDTH        <= W_WORD;
			O_BASE_REG     <= 4'h0;
			O_SRC_REG      <= 4'h0;
			O_SRC_MODE     <= 3'h0;
			O_DST_REG      <= 4'h0;
			O_DST_MODE     <= 3'h0;
			O_DST_USED     <= 1'b0;
			O_FILE_ADDR    <= 13'h0000;
			O_DST_IS_WREG0 <= 1'b0;
			O_ULIT10       <= 10'h000;
			O_SLIT16       <= 16'h0000;
			O_PROG_ADDR    <= 23'h00_0000;
			O_BIT_POS      <= 4'h0;
			O_BIT_INDIRECT <= 1'b0;
			O_ACC_B        <= 1'b0;
			O_AWB_EN       <= 1'b0;
			O_AWB_POSTINC  <= 1'b0;
			O_SHIFT_LIT    <= 1'b0;
			O_SHIFT_AMT    <= 6'h00;
			O_XPF          <= 4'h0;
			O_YPF          <= 4'h0;
			O_FMT_ERR      <= 1'b0;
		end else begin
			O_DEC_VALID <= dv_d; // RULE24
			if (dv_d) begin
				O_OPCODE       <= op;
				O_CLASS        <= cls_d;
				O_TWO_WORD     <= two_d;
				O_CYCLES       <= cyc_d;
				O_WIDTH        <= wid_d;
				O_BASE_REG     <= w[F_BASE_LSB +: 4];
				O_SRC_REG      <= w[F_SRC_LSB +: 4];
				O_SRC_MODE     <= w[F_SMODE +: 3];
				O_DST_REG      <= w[F_DST_LSB +: 4];
				O_DST_MODE     <= w[F_DMODE +: 3];
				O_DST_USED     <= dused_d;
				O_FILE_ADDR    <= w[12:0]; // RULE10
				O_DST_IS_WREG0 <= dwreg_d;
				O_ULIT10       <= ulit_d;
				O_SLIT16       <= slit_d;
				O_PROG_ADDR    <= pa_d;
				O_BIT_POS      <= w[F_BIT_LSB +: 4]; // RULE13
				O_BIT_INDIRECT <= bind_d;
				O_ACC_B        <= w[F_ACC]; // RULE15
				O_AWB_EN       <= awben_d;
				O_AWB_POSTINC  <= awbinc_d;
				O_SHIFT_LIT    <= shlit_d;
				O_SHIFT_AMT    <= sham_d;
				O_XPF          <= w[F_XPF_LSB +: 4];
				O_YPF          <= w[F_YPF_LSB +: 4];
				O_FMT_ERR      <= err_d;
			end
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	// hardware updates win over a software write in the same cycle
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			sr_q <= 9'h000;
		end else begin
			for (int i = 0; i < SR_W; i++) begin
				if (I_SR_MASK[i])
					sr_q[i] <= (i == SR_Z) ? (sr_q[i] & I_SR_VAL[i]) : I_SR_VAL[i]; // RULE16 RULE17
				else if (I_WR && I_ADDR == ADDR_SR)
					sr_q[i] <= I_WDATA[i];
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_SR <= 9'h000;
		end else begin
			O_SR <= sr_q;
		end
	end

	// ****************************************
	// register port
	// ****************************************
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			en_q <= 1'b1;
		end else if (I_WR && I_ADDR == ADDR_CTRL) begin
			en_q <= I_WDATA[0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RDATA <= 32'h0000_0000;
		end else if (I_RD) begin
			unique case (I_ADDR)
				ADDR_CTRL: O_RDATA <= {31'h0000_0000, en_q};
				ADDR_SR:   O_RDATA <= {23'h00_0000, sr_q};
				ADDR_DEC:  O_RDATA <= {16'h0000, O_FMT_ERR, state_q, O_CYCLES, O_CLASS, O_TWO_WORD, O_OPCODE};
				default:   O_RDATA <= 32'h0000_0000;
			endcase
		end else begin
			O_RDATA <= 32'h0000_0000;
		end
	end

endmodule

// File: logic/dfd_pkg.sv
// constants, field positions and types of the instruction format decoder
// assumes one core clock; opcode values below are a fixed local encoding map
package dfd_pkg;

	// ****************************************
	// word layout
	// ****************************************
	localparam int INSN_W     = 24;
	localparam int OP_LSB     = 16;
	localparam int F_BASE_LSB = 15;
	localparam int F_BYTE     = 14;
	localparam int F_DMODE    = 11;
	localparam int F_DST_LSB  = 7;
	localparam int F_SMODE    = 4;
	localparam int F_SRC_LSB  = 0;
	localparam int F_FDIR     = 13;
	localparam int F_LIT_LSB  = 4;
	localparam int F_BIT_LSB  = 12;
	localparam int F_ACC      = 15;
	localparam int F_SHLIT    = 14;
	localparam int F_XPF_LSB  = 6;
	localparam int F_YPF_LSB  = 2;
	localparam int F_AWB_LSB  = 0;
	localparam int F_W2_LSB   = 16;

	// ****************************************
	// opcodes and opcode groups
	// ****************************************
	localparam logic [7:0] OP_NOP   = 8'h00;
	localparam logic [7:0] OP_IND   = 8'h01;
	localparam logic [7:0] OP_CALL  = 8'h02;
	localparam logic [7:0] OP_GOTO  = 8'h04;
	localparam logic [7:0] OP_RET   = 8'h06;
	localparam logic [7:0] OP_RETI  = 8'h07;
	localparam logic [7:0] OP_DO    = 8'h08;
	localparam logic [7:0] OP_TBLR  = 8'h0A;
	localparam logic [7:0] OP_TBLW  = 8'h0B;
	localparam logic [7:0] OP_BRA   = 8'h37;
	localparam logic [7:0] OP_MOVD  = 8'h9E;
	localparam logic [7:0] OP_SKIP0 = 8'hAE;
	localparam logic [7:0] OP_SKIP1 = 8'hAF;
	localparam logic [3:0] NB_CTRL  = 4'h0;
	localparam logic [3:0] NB_SLIT  = 4'h2;
	localparam logic [3:0] NB_BRC   = 4'h3;
	localparam logic [3:0] NB_BIT   = 4'hA;
	localparam logic [3:0] NB_LITF  = 4'hB;
	localparam logic [3:0] NB_DSP   = 4'hC;
	localparam logic [7:0] W2_HIGH  = 8'h00;

	// ****************************************
	// values
	// ****************************************
	localparam logic [1:0] CYC_1       = 2'h1;
	localparam logic [1:0] CYC_2       = 2'h2;
	localparam logic [1:0] CYC_3       = 2'h3;
	localparam logic [2:0] MODE_LIT    = 3'h3;
	localparam logic [1:0] AWB_DIRECT  = 2'h0;
	localparam logic [1:0] AWB_POSTINC = 2'h1;
	localparam logic [9:0] LIT8_MASK   = 10'h0FF;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_SR     = 4'h4;
	localparam logic [3:0] ADDR_DEC    = 4'h8;
	localparam int SR_Z = 4;
	localparam int SR_W = 9;

	typedef enum logic [1:0] {
		W_WORD   = 2'b00,
		W_BYTE   = 2'b01,
		W_DOUBLE = 2'b10
	} dfd_width_t;

	typedef enum logic [2:0] {
		C_NOP     = 3'b000,
		C_DEFAULT_WORKING_REGISTER    = 3'b001,
		C_FILE    = 3'b010,
		C_BIT     = 3'b011,
		C_LIT     = 3'b100,
		C_MAC     = 3'b101,
		C_DSP     = 3'b110,
		C_CTRL    = 3'b111
	} dfd_class_t;

	typedef enum logic {
		ST_FIRST = 1'b0,
		ST_WORD2 = 1'b1
	} dfd_state_t;

endpackage

// File: verif/dfd_chk.sv
// port assertions for the instruction format decoder
// assumes one core clock and an active-low asynchronous reset
`timescale 1ns/100ps
module dfd_chk
	import dfd_pkg::*;
(
	input wire logic        I_CLK,
	input wire logic        I_RST_B,
	input wire logic        I_INSN_VALID,
	input wire logic [23:0] I_INSN,
	input wire logic [23:0] I_NEXT_INSN,
	input wire logic        I_COND_TRUE,
	input wire logic [3:0]  I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        O_DEC_VALID,
	input wire logic [7:0]  O_OPCODE,
	input wire logic [2:0]  O_CLASS,
	input wire logic        O_TWO_WORD,
	input wire logic [1:0]  O_CYCLES,
	input wire logic [1:0]  O_WIDTH,
	input wire logic [12:0] O_FILE_ADDR,
	input wire logic        O_DST_IS_WREG0,
	input wire logic [9:0]  O_ULIT10,
	input wire logic [22:0] O_PROG_ADDR,
	input wire logic        O_ACC_B
);
	// ****************************************
	// helper logic
	// ****************************************
	logic en_q;
	logic p_q;
	logic take;
	logic two;
	logic nx2;
	assign take = I_INSN_VALID && en_q;
	assign two = I_INSN[23:16] inside {OP_CALL, OP_GOTO, OP_DO};
	assign nx2 = I_NEXT_INSN[23:16] inside {OP_CALL, OP_GOTO, OP_DO};
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			en_q <= 1'b1;
		else if (I_WR && I_ADDR == ADDR_CTRL)
			en_q <= I_WDATA[0];
	end
	// second word of a pair is pending
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B)
			p_q <= 1'b0;
		else if (take)
			p_q <= !p_q && two;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_first;
		take && !p_q;
	endsequence
	sequence s_pair;
		s_first ##0 two ##1 take;
	endsequence
	chk_one_word: assert property (
		s_first ##0 !two |=> O_DEC_VALID && !O_TWO_WORD && O_OPCODE == $past(I_INSN[23:16]))
		else $error("one-word decode wrong");
	chk_pair_wait: assert property (
		s_first ##0 two |=> !O_DEC_VALID)
		else $error("early decode on first word");
	chk_pair_done: assert property (
		s_pair |=> O_DEC_VALID && O_TWO_WORD && O_CYCLES == CYC_2 && !O_PROG_ADDR[0])
		else $error("two-word decode wrong");
	chk_file_addr: assert property (
		s_first ##0 I_INSN[23:19] == 5'h17 |=> O_CLASS == C_FILE
			&& O_FILE_ADDR == $past(I_INSN[12:0]) && O_DST_IS_WREG0 == !$past(I_INSN[13]))
		else $error("file operand wrong");
	chk_byte_lit: assert property (
		O_DEC_VALID && O_CLASS == C_LIT && O_WIDTH == W_BYTE |-> O_ULIT10[9:8] == 2'h0)
		else $error("byte literal too wide");
	chk_acc_sel: assert property (
		s_first ##0 I_INSN[23:20] == NB_DSP |=> O_ACC_B == $past(I_INSN[15]))
		else $error("accumulator select wrong");
	chk_ret_cyc: assert property (
		s_first ##0 I_INSN[23:17] == 7'h03 |=> O_CYCLES == CYC_3)
		else $error("return cycles wrong");
	chk_skip_cyc: assert property (
		s_first ##0 I_INSN[23:17] == 7'h57 && I_COND_TRUE |=> O_CYCLES == ($past(nx2) ? CYC_3 : CYC_2))
		else $error("skip cycles wrong");
endmodule

bind dfd_decoder dfd_chk chk_u (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_INSN_VALID(I_INSN_VALID),
	.I_INSN(I_INSN), .I_NEXT_INSN(I_NEXT_INSN), .I_COND_TRUE(I_COND_TRUE), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .O_DEC_VALID(O_DEC_VALID), .O_OPCODE(O_OPCODE),
	.O_CLASS(O_CLASS), .O_TWO_WORD(O_TWO_WORD), .O_CYCLES(O_CYCLES), .O_WIDTH(O_WIDTH),
	.O_FILE_ADDR(O_FILE_ADDR), .O_DST_IS_WREG0(O_DST_IS_WREG0), .O_ULIT10(O_ULIT10),
	.O_PROG_ADDR(O_PROG_ADDR), .O_ACC_B(O_ACC_B));

// File: verif/dfd_fetch_model.sv
// fetch-side partner: hands queued words over, one per valid pulse
// assumes the bench queues words with push; i_slow leaves a gap after each word
`timescale 1ns/100ps
module dfd_fetch_model (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_slow,
	output logic             o_valid = 1'b0,
	output logic [23:0]      o_insn = 24'h00_0000,
	output logic [23:0]      o_next = 24'h00_0000,
	output logic             o_cond = 1'b0
);
	logic [48:0] q_q[$];
	task automatic push(input logic [23:0] w, input logic [23:0] n, input logic c);
		q_q.push_back({c, n, w});
	endtask
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_valid <= 1'b0;
		end else if (q_q.size() != 0 && !(i_slow && o_valid)) begin
			{o_cond, o_next, o_insn} <= q_q.pop_front();
			o_valid <= 1'b1;
		end else begin
			// lines between words do not keep the last value
			o_valid <= 1'b0;
			o_insn <= ~o_insn;
			o_next <= ~o_next;
			o_cond <= ~o_cond;
		end
	end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the instruction format decoder
// assumes the fetch model feeds words and the bench owns the register port
`timescale 1ns/100ps
module tb_top;
	import dfd_pkg::*;
	logic        I_CLK = 1'b0, I_RST_B = 1'b0, I_WR = 1'b0, I_RD = 1'b0, slow = 1'b0;
	logic        I_INSN_VALID, I_COND_TRUE, O_DEC_VALID, O_TWO_WORD, O_DST_USED;
	logic        O_DST_IS_WREG0, O_BIT_INDIRECT, O_ACC_B, O_AWB_EN, O_AWB_POSTINC;
	logic        O_SHIFT_LIT, O_FMT_ERR;
	logic [23:0] I_INSN, I_NEXT_INSN;
	logic [8:0]  I_SR_MASK = 9'h000, I_SR_VAL = 9'h000, O_SR;
	logic [3:0]  I_ADDR = 4'h0, O_BASE_REG, O_SRC_REG, O_DST_REG, O_BIT_POS, O_XPF, O_YPF;
	logic [31:0] I_WDATA = 32'h0000_0000, O_RDATA;
	logic [7:0]  O_OPCODE;
	logic [2:0]  O_CLASS, O_SRC_MODE, O_DST_MODE;
	logic [1:0]  O_CYCLES, O_WIDTH;
	logic [12:0] O_FILE_ADDR;
	logic [9:0]  O_ULIT10;
	logic [15:0] O_SLIT16;
	logic [22:0] O_PROG_ADDR;
	logic [5:0]  O_SHIFT_AMT;
	int          err_total = 0, compares = 0;

	dfd_fetch_model fm_u (.i_clk(I_CLK), .i_rst_b(I_RST_B), .i_slow(slow), .o_valid(I_INSN_VALID),
		.o_insn(I_INSN), .o_next(I_NEXT_INSN), .o_cond(I_COND_TRUE));
	dfd_decoder dut_u (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_INSN_VALID(I_INSN_VALID), .I_INSN(I_INSN),
		.I_NEXT_INSN(I_NEXT_INSN), .I_COND_TRUE(I_COND_TRUE), .I_SR_MASK(I_SR_MASK), .I_SR_VAL(I_SR_VAL),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_DEC_VALID(O_DEC_VALID),
		.O_OPCODE(O_OPCODE), .O_CLASS(O_CLASS), .O_TWO_WORD(O_TWO_WORD), .O_CYCLES(O_CYCLES),
		.O_WIDTH(O_WIDTH), .O_BASE_REG(O_BASE_REG), .O_SRC_REG(O_SRC_REG), .O_SRC_MODE(O_SRC_MODE),
		.O_DST_REG(O_DST_REG), .O_DST_MODE(O_DST_MODE), .O_DST_USED(O_DST_USED), .O_FILE_ADDR(O_FILE_ADDR),
		.O_DST_IS_WREG0(O_DST_IS_WREG0), .O_ULIT10(O_ULIT10), .O_SLIT16(O_SLIT16), .O_PROG_ADDR(O_PROG_ADDR),
		.O_BIT_POS(O_BIT_POS), .O_BIT_INDIRECT(O_BIT_INDIRECT), .O_ACC_B(O_ACC_B), .O_AWB_EN(O_AWB_EN),
		.O_AWB_POSTINC(O_AWB_POSTINC), .O_SHIFT_LIT(O_SHIFT_LIT), .O_SHIFT_AMT(O_SHIFT_AMT), .O_XPF(O_XPF),
		.O_YPF(O_YPF), .O_FMT_ERR(O_FMT_ERR), .O_SR(O_SR), .O_RDATA(O_RDATA));
	always #20 I_CLK = ~I_CLK;

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_WR <= 1'b1;
		I_ADDR <= a;
		I_WDATA <= d;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge I_CLK);
		I_RD <= 1'b1;
		I_ADDR <= a;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 cmp(O_RDATA, e);
	endtask
	// queue a word and wait for its decode pulse
	task automatic dec(input logic [23:0] w, input logic [23:0] n, input logic c);
		int i;
		i = 0;
		fm_u.push(w, n, c);
		do begin
			@(posedge I_CLK);
			#1 i++;
		end while (O_DEC_VALID !== 1'b1 && i < 12);
		cmp(O_DEC_VALID, 1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		rd(ADDR_CTRL, 32'h0000_0001);
		rd(ADDR_SR, 32'h0000_0000);
		wr(ADDR_SR, 32'h0000_0010);
		rd(ADDR_SR, 32'h0000_0010);
		@(posedge I_CLK);
		I_SR_MASK <= 9'h1FF;
		I_SR_VAL <= 9'h1EF;
		@(posedge I_CLK);
		I_SR_MASK <= 9'h010;
		I_SR_VAL <= 9'h010;
		@(posedge I_CLK);
		I_SR_MASK <= 9'h000;
		repeat (2) @(posedge I_CLK);
		#1 cmp(O_SR, 9'h1EF);
		// hardware update of the carry beats a software write in the same cycle
		@(posedge I_CLK);
		I_SR_MASK <= 9'h001;
		I_SR_VAL <= 9'h000;
		I_WR <= 1'b1;
		I_ADDR <= ADDR_SR;
		I_WDATA <= 32'h0000_01FF;
		@(posedge I_CLK);
		I_SR_MASK <= 9'h000;
		I_WR <= 1'b0;
		rd(ADDR_SR, 32'h0000_01FE);
		wr(4'hC, 32'h0000_FFFF);
		rd(4'hC, 32'h0000_0000);
	endtask
	task automatic t_fields;
		dec(24'hB8_1ABC, 24'h00_0000, 1'b0);
		cmp({O_DST_IS_WREG0, O_FILE_ADDR}, 14'h3ABC);
		dec(24'hB0_7A50, 24'h00_0000, 1'b0);
		cmp({O_FMT_ERR, O_WIDTH, O_ULIT10}, {1'b1, W_BYTE, 10'h0A5});
		dec(24'hB0_3A50, 24'h00_0000, 1'b0);
		cmp({O_DST_USED, O_WIDTH, O_ULIT10}, {1'b0, W_WORD, 10'h3A5});
		dec(24'h20_2000, 24'h00_0000, 1'b0);
		cmp(O_SLIT16, 16'hFE00);
		dec(24'hA1_F000, 24'h00_0000, 1'b0);
		cmp({O_BIT_INDIRECT, O_BIT_POS}, 5'h1F);
		dec(24'hC0_81A5, 24'h00_0000, 1'b0);
		cmp({O_ACC_B, O_AWB_EN, O_AWB_POSTINC, O_XPF, O_YPF}, {3'h7, 4'h6, 4'h9});
		dec(24'hC0_0000, 24'h00_0000, 1'b0);
		cmp({O_ACC_B, O_AWB_EN, O_AWB_POSTINC}, 3'h2);
		dec(24'hC0_0002, 24'h00_0000, 1'b0);
		cmp({O_ACC_B, O_AWB_EN, O_AWB_POSTINC}, 3'h0);
		dec(24'hC8_4025, 24'h00_0000, 1'b0);
		cmp({O_SHIFT_LIT, O_SHIFT_AMT}, 7'h65);
		dec(24'hC8_0007, 24'h00_0000, 1'b0);
		cmp({O_SHIFT_LIT, O_SHIFT_AMT}, 7'h07);
		dec(24'h40_1AA5, 24'h00_0000, 1'b0);
		cmp({O_SRC_REG, 1'b0, O_SRC_MODE, O_DST_REG, 1'b0, O_DST_MODE}, 16'h5253);
	endtask
	task automatic t_cycles;
		logic [23:0] w[12] = '{24'h06_0000, 24'h07_0000, 24'h01_0000, 24'h0A_0000, 24'h0B_0000,
			24'h37_0000, 24'h30_0000, 24'h30_0000, 24'hAE_0000, 24'hAF_0000, 24'hAE_0000, 24'h40_0000};
		logic [23:0] n[12] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0000,
			24'h00_0000, 24'h00_0000, 24'h02_0000, 24'h40_0000, 24'h04_0000, 24'h00_0000};
		logic c[12] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		logic [1:0] e[12] = '{CYC_3, CYC_3, CYC_2, CYC_2, CYC_2, CYC_2, CYC_2, CYC_1, CYC_3, CYC_2, CYC_1, CYC_1};
		slow = 1'b1;
		for (int i = 0; i < 12; i++) begin
			dec(w[i], n[i], c[i]);
			cmp(O_CYCLES, e[i]);
		end
		dec(24'h9E_0000, 24'h00_0000, 1'b0);
		cmp({O_WIDTH, O_CYCLES}, {W_DOUBLE, CYC_2});
		rd(ADDR_DEC, {16'h0000, 1'b0, 1'b0, CYC_2, C_DEFAULT_WORKING_REGISTER, 1'b0, OP_MOVD});
		dec(24'h37_8ABC, 24'h00_0000, 1'b0);
		cmp({O_CYCLES, O_SLIT16}, {CYC_2, 16'h8ABC});
		slow = 1'b0;
	endtask
	task automatic t_gate;
		wr(ADDR_CTRL, 32'h0000_0000);
		fm_u.push(24'h40_0000, 24'h00_0000, 1'b0);
		repeat (4) begin
			@(posedge I_CLK);
			#1 cmp(O_DEC_VALID, 0);
		end
		rd(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_0001);
		dec(24'h41_8A35, 24'h00_0000, 1'b0);
		cmp({O_DST_USED, O_BASE_REG, O_ULIT10}, {1'b1, 4'h3, 10'h015});
		dec(24'h41_89B5, 24'h00_0000, 1'b0);
		cmp({O_DST_USED, O_BASE_REG, O_ULIT10}, {1'b0, 4'h3, 10'h015});
	endtask
	task automatic t_two;
		fm_u.push(24'h02_ABCE, 24'h00_0000, 1'b0);
		dec(24'h00_0045, 24'h00_0000, 1'b0);
		cmp({O_FMT_ERR, O_TWO_WORD, O_CYCLES, O_PROG_ADDR}, {2'b01, CYC_2, 23'h45_ABCE});
		fm_u.push(24'h04_0000, 24'h00_0000, 1'b0);
		dec(24'h01_0000, 24'h00_0000, 1'b0);
		cmp(O_FMT_ERR, 1);
		fm_u.push(24'h08_0000, 24'h00_0000, 1'b0);
		dec(24'h00_0000, 24'h00_0000, 1'b0);
		cmp({O_TWO_WORD, O_CYCLES}, {1'b1, CYC_2});
		dec(24'h00_0045, 24'h00_0000, 1'b0);
		cmp({O_TWO_WORD, O_CLASS}, {1'b0, C_NOP});
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic results;
		$display("err_total=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge I_CLK);
		I_RST_B <= 1'b1;
		t_regs;
		t_fields;
		t_cycles;
		t_two;
		t_gate;
		results;
	end
	initial begin
		#100_000;
		err_total++;
		results;
	end
endmodule
